// >>> ring_engine_defs.svh
// Register offsets, field positions and values, and ring geometry of the ring engine.
`ifndef RING_ENGINE_DEFS_SVH
`define RING_ENGINE_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_QUEUE_SIZE 12'h000
`define OFS_QUEUE_PFN 12'h004
`define OFS_QUEUE_NOTIFY 12'h008
`define OFS_CAUSE 12'h00c
`define OFS_QUEUE_VECTOR 12'h010
`define OFS_CONFIG_VECTOR 12'h014
`define OFS_CONTROL 12'h018
`define OFS_STATUS 12'h01c

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define CTL_EVENT_IDX 0
`define CTL_MSIX_EN 1
`define CAUSE_QUEUE 0
`define CAUSE_CONFIG 6
`define AVAIL_NO_INTERRUPT 0
`define NO_VECTOR 16'hffff
`define OWN_QUEUE_NUMBER 16'h0000

// ----------------------------------------------------------------
// Ring geometry (queue size is a power of two, at most 32768)
// ----------------------------------------------------------------
`define QUEUE_SIZE 32'h0000_0100
`define DESC_BYTES 32'h0000_0010
`define PAGE_BYTES 32'h0000_1000
`define USED_ELEM_BYTES 32'h0000_0008

`endif

// >>> ring_engine_pkg.sv
// Types shared by the ring engine: engine states.
package ring_engine_pkg;

  // ----------------------------------------------------------------
  // Engine states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'b0_0000_0001,
    ST_AIDX  = 9'b0_0000_0010,
    ST_HEAD  = 9'b0_0000_0100,
    ST_SERVE = 9'b0_0000_1000,
    ST_UID   = 9'b0_0001_0000,
    ST_ULEN  = 9'b0_0010_0000,
    ST_UIDX  = 9'b0_0100_0000,
    ST_FLAGS = 9'b0_1000_0000,
    ST_EVENT = 9'b1_0000_0000
  } eng_state_t;

endpackage : ring_engine_pkg

// >>> ring_engine.sv
// Descriptor-ring queue engine: APB registers, ring walker and interrupt decision.
// How it works
// R1: Driver fills descriptor address, length, flags, next.
// R2: Buffers hold elements, read-only before write-only.
// R3: Driver writes heads at published index plus added.
// R4: Free-running 16-bit index; entries visible once covered.
// R5: Reported queue size is power of two.
// R6: Doorbell write of queue number starts processing.
// R7: Driver publishes index before reading suppression hints.
// R8: Without event index, driver honours no-notify flag.
// R9: With event index, driver uses wrapping compare.
// R10: Write used entry first, then advance used index.
// R11: Without event index, interrupt unless no-interrupt flag.
// R12: With event index, interrupt when used crosses event.
// R13: Legacy mode sets cause bit zero, raises interrupt.
// R14: Message mode sends queue vector unless none.
// R15: Reading cause register returns it and clears.
// R16: Legacy handler ignores interrupt when bit zero clear.
// R17: Message handler scans queues of fired vector.
// R18: Driver rechecks ring after re-enabling interrupts.
// R19: Config change sets cause bit six, interrupts.
// R20: Driver scans queues even with config bit.
// R21: Config change in message mode uses config vector.
// R22: Doorbells while suppressed are always accepted.
// R23: Available flags one means no interrupt wanted.
// R24: Used entry pairs head id with written bytes.
// R25: Private consumed count bounds fetches to published index.
`timescale 1ns/1ps
`include "ring_engine_defs.svh"

module ring_engine
  import ring_engine_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared-memory master, request held until ack
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Buffer hand-off to the device function
  output logic chain_valid,
  output logic [15:0] chain_head,
  input wire logic chain_done,
  input wire logic [31:0] chain_written,
  // Configuration change event from the device function
  input wire logic cfg_change,
  // Interrupt outputs
  output logic intx,
  output logic msix_req,
  output logic [15:0] msix_vector
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  eng_state_t state_q, state_d;
  logic [31:0] pfn_q;          // Queue page frame number
  logic [15:0] qvec_q;         // Queue vector
  logic [15:0] cvec_q;         // Configuration vector
  logic [1:0] ctl_q;           // Event-index and message enables
  logic [7:0] cause_q, cause_d;
  logic kick_q;                // Doorbell seen, not yet served
  logic [15:0] last_avail_q;   // Private consumed count
  logic [15:0] avail_idx_q;    // Last published index read
  logic [15:0] used_idx_q;     // Device's used index
  logic [15:0] old_used_q;     // Used index before last update
  logic [15:0] head_q;         // Current chain head
  logic [31:0] wlen_q;         // Bytes written into current chain
  logic avail_flags_q;         // No-interrupt hint
  logic cfg_pend_q;            // Config message waiting its turn
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic mem_req_q, mem_we_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic [3:0] mem_be_q;
  logic chain_valid_q;
  logic intx_q, msix_req_q;
  logic [15:0] msix_vector_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: data comes from a flop, so the access phase
  // always takes two cycles.
  wire apb_setup_done = psel & penable & ~pready_q;
  wire apb_fire = psel & penable & pready_q;
  wire apb_wr = apb_fire & pwrite;
  wire apb_rd = apb_fire & ~pwrite;
  wire hit_size = (paddr == `OFS_QUEUE_SIZE);
  wire hit_pfn = (paddr == `OFS_QUEUE_PFN);
  wire hit_notify = (paddr == `OFS_QUEUE_NOTIFY);
  wire hit_cause = (paddr == `OFS_CAUSE);
  wire hit_qvec = (paddr == `OFS_QUEUE_VECTOR);
  wire hit_cvec = (paddr == `OFS_CONFIG_VECTOR);
  wire hit_ctl = (paddr == `OFS_CONTROL);
  wire hit_stat = (paddr == `OFS_STATUS);
  wire hit_any = hit_size | hit_pfn | hit_notify | hit_cause | hit_qvec | hit_cvec
               | hit_ctl | hit_stat;
  // Read mux; the doorbell reads back as zero
  wire [31:0] rd_mux =
      hit_size ? `QUEUE_SIZE : // see R5
      hit_pfn ? pfn_q :
      hit_cause ? {24'h00_0000, cause_q} :
      hit_qvec ? {16'h0000, qvec_q} :
      hit_cvec ? {16'h0000, cvec_q} :
      hit_ctl ? {30'h0000_0000, ctl_q} :
      hit_stat ? {used_idx_q, last_avail_q} : 32'h0000_0000;
  // Doorbell for our queue; accepted whatever the hints say
  wire doorbell = apb_wr & hit_notify & (pwdata[15:0] == `OWN_QUEUE_NUMBER); // see R6, R22
  wire cause_rd = apb_rd & hit_cause;

  // ----------------------------------------------------------------
  // Ring geometry
  // ----------------------------------------------------------------
  wire [15:0] qmask = 16'(`QUEUE_SIZE - 32'h1);
  wire [31:0] ring_base = {pfn_q[19:0], 12'h000};
  wire [31:0] avail_base = ring_base + `QUEUE_SIZE * `DESC_BYTES;
  wire [31:0] avail_end = avail_base + 32'h4 + 32'h2 * `QUEUE_SIZE + 32'h2;
  wire [31:0] used_base = (avail_end + `PAGE_BYTES - 32'h1) & ~(`PAGE_BYTES - 32'h1);
  wire [31:0] head_addr = avail_base + 32'h4 + {15'h0000, last_avail_q & qmask, 1'b0};
  wire [31:0] event_addr = avail_base + 32'h4 + 32'h2 * `QUEUE_SIZE;
  wire [31:0] elem_addr = used_base + 32'h4 + {13'h0000, used_idx_q & qmask, 3'b000};
  // Halfword picked from the word just returned
  wire [15:0] rd_half = mem_addr_q[1] ? mem_rdata[31:16] : mem_rdata[15:0];

  // ----------------------------------------------------------------
  // Memory request selection per state
  // ----------------------------------------------------------------
  wire st_mem = (state_q == ST_AIDX) | (state_q == ST_HEAD) | (state_q == ST_UID)
              | (state_q == ST_ULEN) | (state_q == ST_UIDX) | (state_q == ST_FLAGS)
              | (state_q == ST_EVENT);
  wire issue = st_mem & ~mem_req_q;
  wire done = mem_req_q & mem_ack;
  wire sel_we = (state_q == ST_UID) | (state_q == ST_ULEN) | (state_q == ST_UIDX);
  wire [31:0] sel_addr =
      (state_q == ST_HEAD) ? {head_addr[31:2], 2'b00} :
      (state_q == ST_UID) ? elem_addr :
      (state_q == ST_ULEN) ? elem_addr + 32'h4 :
      (state_q == ST_UIDX) ? used_base :
      (state_q == ST_EVENT) ? {event_addr[31:2], 2'b00} : avail_base;
  // Used entry pairs head id with bytes written
  wire [31:0] sel_wdata =
      (state_q == ST_UID) ? {16'h0000, head_q} : // see R24
      (state_q == ST_ULEN) ? wlen_q : // see R24
      {16'(used_idx_q + 16'h1), 16'h0000};
  // Index write touches only the upper half, flags stay zero
  wire [3:0] sel_be = (state_q == ST_UIDX) ? 4'b1100 : 4'b1111;

  // ----------------------------------------------------------------
  // Interrupt decision
  // ----------------------------------------------------------------
  // Same wrapping compare the driver uses for its side
  wire [15:0] ev_dist = 16'(used_idx_q - rd_half - 16'h1);
  wire [15:0] moved = 16'(used_idx_q - old_used_q);
  wire want_evt = (ev_dist < moved); // see R12
  wire want_flag = ~avail_flags_q; // see R11, R23
  wire want_irq = (state_q == ST_EVENT) & done & (ctl_q[`CTL_EVENT_IDX] ? want_evt : want_flag);
  wire msix_on = ctl_q[`CTL_MSIX_EN];
  wire q_msg = want_irq & msix_on & (qvec_q != `NO_VECTOR); // see R14
  wire cfg_msg_ok = msix_on & (cvec_q != `NO_VECTOR); // see R21
  wire cfg_now = (cfg_change | cfg_pend_q) & cfg_msg_ok & ~q_msg;
  // A read clears only the bits it returned, so an event that lands
  // between capture and clear is not lost; a set always wins.
  always_comb begin
    cause_d = cause_rd ? (cause_q & ~prdata_q[7:0]) : cause_q; // see R15
    if (want_irq & ~msix_on) begin
      cause_d[`CAUSE_QUEUE] = 1'b1; // see R13
    end
    if (cfg_change & ~msix_on) begin
      cause_d[`CAUSE_CONFIG] = 1'b1; // see R19
    end
  end

  // ----------------------------------------------------------------
  // Engine next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (kick_q) begin
          state_d = ST_AIDX;
        end
      end
      // Only entries the published index covers are fetched
      ST_AIDX: begin
        if (done) begin
          state_d = (mem_rdata[31:16] != last_avail_q) ? ST_HEAD : ST_IDLE; // see R4, R25
        end
      end
      ST_HEAD: begin
        if (done) begin
          state_d = ST_SERVE;
        end
      end
      ST_SERVE: begin
        if (chain_done) begin
          state_d = ST_UID;
        end
      end
      ST_UID: begin
        if (done) begin
          state_d = ST_ULEN;
        end
      end
      // Index advances only after the entry is in memory
      ST_ULEN: begin
        if (done) begin
          state_d = ST_UIDX; // see R10
        end
      end
      ST_UIDX: begin
        if (done) begin
          state_d = ST_FLAGS;
        end
      end
      ST_FLAGS: begin
        if (done) begin
          state_d = ST_EVENT;
        end
      end
      // Go round again: more may have been published meanwhile
      ST_EVENT: begin
        if (done) begin
          state_d = ST_AIDX;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB registers and answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfn_q <= 32'h0000_0000;
      qvec_q <= `NO_VECTOR;
      cvec_q <= `NO_VECTOR;
      ctl_q <= 2'b00;
      cause_q <= 8'h00;
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup_done;
      prdata_q <= (apb_setup_done & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_q <= apb_setup_done & ~hit_any;
      cause_q <= cause_d;
      if (apb_wr & hit_pfn) begin
        pfn_q <= pwdata;
      end
      if (apb_wr & hit_qvec) begin
        qvec_q <= pwdata[15:0];
      end
      if (apb_wr & hit_cvec) begin
        cvec_q <= pwdata[15:0];
      end
      if (apb_wr & hit_ctl) begin
        ctl_q <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Engine registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      kick_q <= 1'b0;
      last_avail_q <= 16'h0000;
      avail_idx_q <= 16'h0000;
      used_idx_q <= 16'h0000;
      old_used_q <= 16'h0000;
      head_q <= 16'h0000;
      wlen_q <= 32'h0000_0000;
      avail_flags_q <= 1'b0;
      chain_valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // A doorbell during a pass re-arms for one more look
      if (doorbell) begin
        kick_q <= 1'b1; // see R6
      end else if ((state_q == ST_AIDX) & done) begin
        kick_q <= 1'b0;
      end
      if ((state_q == ST_AIDX) & done) begin
        avail_idx_q <= mem_rdata[31:16];
      end
      if ((state_q == ST_HEAD) & done) begin
        head_q <= rd_half;
        last_avail_q <= 16'(last_avail_q + 16'h1); // see R25
        chain_valid_q <= 1'b1;
      end
      if ((state_q == ST_SERVE) & chain_done) begin
        wlen_q <= chain_written;
        chain_valid_q <= 1'b0;
      end
      if ((state_q == ST_UIDX) & done) begin
        old_used_q <= used_idx_q;
        used_idx_q <= 16'(used_idx_q + 16'h1); // see R10
      end
      if ((state_q == ST_FLAGS) & done) begin
        avail_flags_q <= mem_rdata[`AVAIL_NO_INTERRUPT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory master
  // ----------------------------------------------------------------
  // Request is held with its fields until the ack edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
      mem_be_q <= 4'b0000;
    end else if (issue) begin
      mem_req_q <= 1'b1;
      mem_we_q <= sel_we;
      mem_addr_q <= (state_q == ST_HEAD) ? head_addr : sel_addr;
      mem_wdata_q <= sel_wdata;
      mem_be_q <= sel_be;
    end else if (done) begin
      mem_req_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt delivery
  // ----------------------------------------------------------------
  // Queue message wins a clash; the config message follows next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intx_q <= 1'b0;
      msix_req_q <= 1'b0;
      msix_vector_q <= 16'h0000;
      cfg_pend_q <= 1'b0;
    end else begin
      intx_q <= (cause_d != 8'h00) & ~msix_on; // see R13, R19
      msix_req_q <= q_msg | cfg_now;
      if (q_msg) begin
        msix_vector_q <= qvec_q; // see R14
      end else if (cfg_now) begin
        msix_vector_q <= cvec_q; // see R21
      end
      cfg_pend_q <= (cfg_change | cfg_pend_q) & cfg_msg_ok & q_msg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_be = mem_be_q;
  assign chain_valid = chain_valid_q;
  assign chain_head = head_q;
  assign intx = intx_q;
  assign msix_req = msix_req_q;
  assign msix_vector = msix_vector_q;

endmodule : ring_engine

// >>> ring_engine_checker.sv
// Concurrent checks on the ring engine's ports, bound into the engine.
`timescale 1ns/1ps
`include "ring_engine_defs.svh"

module ring_engine_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Memory master
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  input wire logic mem_ack,
  // Chain hand-off and events
  input wire logic chain_valid,
  input wire logic [15:0] chain_head,
  input wire logic chain_done,
  input wire logic cfg_change,
  // Interrupt outputs
  input wire logic intx,
  input wire logic msix_req,
  input wire logic [15:0] msix_vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------
  // Helper: last acknowledged write was a full word
  // ----------------
  logic full_q; // Used index may only follow a full-word entry write
  wire acc_w = psel && penable; // Access phase in progress
  wire cause_rd = acc_w && pready && !pwrite && (paddr == `OFS_CAUSE); // Cause read lands

  // Tracks the kind of the last completed memory write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
    end else if (mem_req && mem_ack && mem_we) begin
      full_q <= (mem_be == 4'hf);
    end
  end

  // ----------------
  // Assertions
  // ----------------
  a_one_wait: assert property (acc_w && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  a_cause_clear: assert property (cause_rd && !cfg_change && !chain_valid |-> ##2 !intx)
    else $error("interrupt stays after cause read");
  a_intx_hold: assert property (intx && !acc_w && !$past(acc_w) |=> intx)
    else $error("interrupt dropped without a read");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata) && $stable(mem_be))
    else $error("memory request changed before ack");
  a_mem_release: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request kept after ack");
  a_used_order: assert property (mem_req && mem_we && mem_be == 4'b1100 |-> full_q)
    else $error("used index written before entry");
  a_chain_hold: assert property (chain_valid && !chain_done |=> chain_valid
    && $stable(chain_head))
    else $error("chain hand-off dropped early");
  a_vector_real: assert property (msix_req |-> msix_vector != `NO_VECTOR)
    else $error("message sent with no vector");

  // Main scenarios reached
  c_message: cover property (msix_req);
  c_legacy: cover property ($rose(intx));
  c_chain: cover property (chain_valid && chain_done);
endmodule : ring_engine_checker

bind ring_engine ring_engine_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_be(mem_be), .mem_ack(mem_ack), .chain_valid(chain_valid), .chain_head(chain_head),
  .chain_done(chain_done), .cfg_change(cfg_change), .intx(intx), .msix_req(msix_req),
  .msix_vector(msix_vector));

// >>> ring_mem_model.sv
// Shared guest memory: answers the engine's memory requests after a set delay.
`timescale 1ns/1ps

module ring_mem_model #(
  parameter logic [31:0] EV_ADDR = 32'h0000_2204
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory port of the engine
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay and event-field read count
  input wire logic [3:0] lat,
  output int ev_reads
);
  logic [31:0] mem [int]; // Word store keyed by word address
  logic [3:0] wait_q; // Cycles already waited
  logic [31:0] t; // Word under update
  int w; // Word key of the request

  // ----------------
  // Answer process
  // ----------------
  // Idle data is the inverse of the last word so stale values never match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 32'h0;
      ev_reads <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_q < lat) begin
      wait_q <= wait_q + 4'h1;
    end else if (mem_req) begin
      w = int'(mem_addr >> 2);
      t = mem.exists(w) ? mem[w] : 32'h0;
      for (int b = 0; b < 4; b++) begin
        if (mem_we && mem_be[b]) t[8*b +: 8] = mem_wdata[8*b +: 8];
      end
      mem[w] = t;
      mem_rdata <= mem_we ? ~mem_rdata : t;
      if (mem_addr == EV_ADDR) ev_reads <= ev_reads + 1;
      mem_ack <= 1'b1;
      wait_q <= 4'h0;
    end
  end
endmodule : ring_mem_model

// >>> tb_descriptor_ring_queue_engine.sv
// Self-checking bench: driver software over APB, shared memory and device function.
`timescale 1ns/1ps
`include "ring_engine_defs.svh"

module tb_descriptor_ring_queue_engine;
  // ----------------
  // Signals
  // ----------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata, rdat;
  logic [31:0] chain_written = 32'h0;
  logic pready, pslverr, mem_req, mem_we, mem_ack, chain_valid, intx, msix_req, rerr;
  logic chain_done = 1'b0, cfg_change = 1'b0;
  logic [3:0] mem_be, lat = 4'h0;
  logic [15:0] chain_head, msix_vector, msix_last, aidx = 16'h0, uidx = 16'h0;
  int ev_reads, msix_cnt = 0, error_cnt = 0, n_compared = 0, m;
  localparam logic [31:0] AV = 32'h0000_2000; // Available ring, ring page 1
  localparam logic [31:0] UB = 32'h0000_3000; // Used ring

  ring_engine i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .chain_valid(chain_valid), .chain_head(chain_head), .chain_done(chain_done),
    .chain_written(chain_written), .cfg_change(cfg_change), .intx(intx),
    .msix_req(msix_req), .msix_vector(msix_vector));
  ring_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .lat(lat), .ev_reads(ev_reads));

  // Clock at 20 MHz
  initial begin
    forever #25 pclk = ~pclk;
  end
  // Message monitor: count and last vector
  always @(posedge pclk) begin
    if (msix_req === 1'b1) begin
      msix_cnt++;
      msix_last = msix_vector;
    end
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Halfword store into guest memory
  task automatic put16(input logic [31:0] a, input logic [15:0] v);
    logic [31:0] t;
    t = i_mem.mem.exists(int'(a >> 2)) ? i_mem.mem[int'(a >> 2)] : 32'h0;
    if (a[1]) t[31:16] = v;
    else t[15:0] = v;
    i_mem.mem[int'(a >> 2)] = t;
  endtask : put16
  // Driver publishes one chain head
  task automatic post(input logic [15:0] head);
    i_mem.mem[int'((32'h1000 + 16 * head) >> 2)] = 32'h0000_8000;
    put16(AV + 4 + 2 * (aidx % 16'd256), head);
    aidx = aidx + 16'd1;
    put16(AV + 2, aidx);
  endtask : post
  // Device function serves the chain, then the used ring is checked
  task automatic serve(input logic [15:0] head, input logic [31:0] len);
    int n, e;
    n = 0;
    while (chain_valid !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 300), 32'h1);
    chk(32'(chain_head), 32'(head));
    e = ev_reads;
    chain_written <= len;
    chain_done <= 1'b1;
    @(posedge pclk);
    chain_done <= 1'b0;
    n = 0;
    while (ev_reads == e && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 300), 32'h1);
    repeat (5) @(posedge pclk);
    chk(i_mem.mem[int'((UB + 4 + 8 * (uidx % 16'd256)) >> 2)], {16'h0, head});
    chk(i_mem.mem[int'((UB + 8 + 8 * (uidx % 16'd256)) >> 2)], len);
    uidx = uidx + 16'd1;
    chk(i_mem.mem[int'(UB >> 2)] & 32'hffff_0000, {uidx, 16'h0});
  endtask : serve
  task automatic chain(input logic [15:0] head, input logic [31:0] len);
    post(head);
    apb(1'b1, `OFS_QUEUE_NOTIFY, 32'h0);
    serve(head, len);
  endtask : chain
  task automatic pulse_cfg();
    @(posedge pclk);
    cfg_change <= 1'b1;
    @(posedge pclk);
    cfg_change <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : pulse_cfg
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ----------------
  // Watchdog and main sequence
  // ----------------
  initial begin
    #(50 * 30000);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_QUEUE_SIZE, 32'h0); chk(rdat, 32'h100);
    apb(1'b0, `OFS_QUEUE_VECTOR, 32'h0); chk(rdat & 32'hffff, 32'hffff);
    apb(1'b0, `OFS_CONFIG_VECTOR, 32'h0); chk(rdat & 32'hffff, 32'hffff);
    apb(1'b0, 12'h020, 32'h0); chk(32'(rerr), 32'h1);
    apb(1'b1, `OFS_QUEUE_PFN, 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    chain(16'd5, 32'h40);
    chk(32'(intx), 32'h1);
    apb(1'b0, `OFS_CAUSE, 32'h0); chk(rdat, 32'h1);
    apb(1'b0, `OFS_CAUSE, 32'h0); chk(rdat, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(intx), 32'h0);
    lat <= 4'h3;
    put16(AV, 16'h1);
    chain(16'd7, 32'h10);
    chk(32'(intx), 32'h0);
    put16(AV, 16'h0);
    apb(1'b1, `OFS_CONTROL, 32'h1);
    put16(AV + 4 + 512, 16'h0);
    chain(16'd9, 32'h4);
    chk(32'(intx), 32'h0);
    put16(AV + 4 + 512, 16'h3);
    chain(16'd11, 32'h8);
    chk(32'(intx), 32'h1);
    apb(1'b0, `OFS_CAUSE, 32'h0); chk(rdat, 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h2);
    apb(1'b1, `OFS_QUEUE_VECTOR, 32'h3);
    m = msix_cnt;
    chain(16'd13, 32'h1);
    chk(msix_cnt - m, 32'h1);
    chk(32'(msix_last), 32'h3);
    apb(1'b1, `OFS_QUEUE_VECTOR, 32'hffff);
    m = msix_cnt;
    chain(16'd15, 32'h2);
    chk(msix_cnt - m, 32'h0);
    apb(1'b1, `OFS_CONFIG_VECTOR, 32'h5);
    m = msix_cnt;
    pulse_cfg();
    chk(msix_cnt - m, 32'h1);
    chk(32'(msix_last), 32'h5);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    pulse_cfg();
    chk(32'(intx), 32'h1);
    apb(1'b0, `OFS_CAUSE, 32'h0); chk(rdat, 32'h40);
    lat <= 4'h0;
    post(16'd17);
    apb(1'b1, `OFS_QUEUE_NOTIFY, 32'h1);
    repeat (30) @(posedge pclk);
    chk(32'(chain_valid), 32'h0);
    apb(1'b1, `OFS_QUEUE_NOTIFY, 32'h0);
    serve(16'd17, 32'h3);
    apb(1'b0, `OFS_STATUS, 32'h0); chk(rdat, {16'd7, 16'd7});
    final_report();
  end
endmodule : tb_descriptor_ring_queue_engine
